// ==== inc/mpcr_pkg.sv ====
// shared constants and types for the metering path configuration bank
//
// Contract
// - config bit 0 routes currents through integrator
// - config bit 3 swaps voltage and current outputs
// - config bit 4 grounds voltage converter inputs
// - config bit 5 grounds current converter inputs
// - config bit 6 enables capture port, clock on pin
// - bit 6 clear returns pin to pulse output
// - writing config bit 7 starts software reset
// - bits 9:8 pick voltage paired with phase A
// - bits 11:10 pick voltage paired with phase B
// - bits 13:12 pick voltage paired with phase C
// - pairing code 11 behaves as code 00
// - neutral source 0 loads measured neutral rms
// - mode bits 1:0 pick line period phase
// - mode bits 2..4 enable phase peak sources
// - several peak phases count all zero crossings
// - reserved bits have no effect
package mpcr_pkg;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [15:0] MEAS_MODE_ADDR = 16'he700;
	localparam logic [15:0] NEUTRAL_CFG_ADDR = 16'he740;
	localparam logic [15:0] PATH_CFG_ADDR = 16'he780;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [7:0] MEAS_MODE_RESET = 8'h1c;
	localparam logic [7:0] NEUTRAL_CFG_RESET = 8'h00;
	localparam logic [15:0] PATH_CFG_RESET = 16'h0000;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int INTEGRATOR_ENABLE_BIT = 0;
	localparam int CHANNEL_SWAP_BIT = 3;
	localparam int VOLTAGE_ADC_GROUND_BIT = 4;
	localparam int CURRENT_ADC_GROUND_BIT = 5;
	localparam int FAST_CAPTURE_PORT_ENABLE_BIT = 6;
	localparam int SOFT_RESET_REQUEST_BIT = 7;
	localparam int PHASE_A_PAIRING_LSB = 8;
	localparam int PHASE_B_PAIRING_LSB = 10;
	localparam int PHASE_C_PAIRING_LSB = 12;
	localparam int NEUTRAL_RMS_SOURCE_BIT = 0;
	localparam int LINE_PERIOD_SELECT_LSB = 0;
	localparam int PEAK_PHASE_SELECT_LSB = 2;
	localparam logic [15:0] PATH_CFG_LIVE_MASK = 16'h3ff9;
	localparam logic [7:0] MEAS_MODE_LIVE_MASK = 8'h1f;
	localparam logic [7:0] NEUTRAL_CFG_LIVE_MASK = 8'h01;

	// ------------------------------------------------------------
	// bus answers and sample layout
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int SAMPLE_W = 24;

	typedef struct packed {
		logic [SAMPLE_W-1:0] va;
		logic [SAMPLE_W-1:0] vb;
		logic [SAMPLE_W-1:0] vc;
		logic [SAMPLE_W-1:0] ia;
		logic [SAMPLE_W-1:0] ib;
		logic [SAMPLE_W-1:0] ic;
		logic [SAMPLE_W-1:0] in;
	} mpcr_samples_type;

	typedef struct packed {
		logic [SAMPLE_W-1:0] va;
		logic [SAMPLE_W-1:0] vb;
		logic [SAMPLE_W-1:0] vc;
	} mpcr_pair_type;

endpackage

// ==== verilog/mpcr_top.sv ====
// configuration bank and signal path steering for the metering path
`timescale 1ns/1ps
`default_nettype none

module mpcr_top #(
	parameter int RMS_W = 24
) (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic I_CE,
	input wire logic [15:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	output logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	output logic O_AXI_WREADY,
	output logic [1:0] O_AXI_BRESP,
	output logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic [15:0] I_AXI_ARADDR,
	input wire logic I_AXI_ARVALID,
	output logic O_AXI_ARREADY,
	output logic [31:0] O_AXI_RDATA,
	output logic [1:0] O_AXI_RRESP,
	output logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	input wire mpcr_pkg::mpcr_samples_type I_RAW_SAMPLES,
	input wire mpcr_pkg::mpcr_samples_type I_INTEG_SAMPLES,
	input wire logic [2:0] I_PHASE_ZERO_CROSS,
	input wire logic [RMS_W-1:0] I_NEUTRAL_RMS_MEASURED,
	input wire logic [RMS_W-1:0] I_NEUTRAL_RMS_ESTIMATED,
	input wire logic I_THIRD_PULSE,
	input wire logic I_FAST_CAPTURE_CLOCK,
	output mpcr_pkg::mpcr_samples_type O_CHANNEL_SAMPLES,
	output mpcr_pkg::mpcr_pair_type O_POWER_VOLTAGE,
	output logic O_LINE_PERIOD_ZERO_CROSS,
	output logic O_PEAK_ZERO_CROSS,
	output logic [2:0] O_PEAK_PHASE_SELECT,
	output logic [RMS_W-1:0] O_NEUTRAL_RMS_RESULT,
	output logic O_FAST_CAPTURE_PORT_ENABLE,
	output logic O_THIRD_PULSE_PIN,
	output logic O_SOFT_RESET
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// code 00 and the reserved 11 both keep the phase's own voltage
	function automatic logic [mpcr_pkg::SAMPLE_W-1:0] pair_pick(
		input logic [1:0] code,
		input logic [mpcr_pkg::SAMPLE_W-1:0] own,
		input logic [mpcr_pkg::SAMPLE_W-1:0] nxt,
		input logic [mpcr_pkg::SAMPLE_W-1:0] prv
	);
		logic [mpcr_pkg::SAMPLE_W-1:0] res;
		unique case (code)
			2'h1: res = nxt;
			2'h2: res = prv;
			default: res = own;
		endcase
		return res;
	endfunction

	// byte-lane merge of a write into a stored word
	function automatic logic [31:0] lane_merge(
		input logic [31:0] old,
		input logic [31:0] data,
		input logic [3:0] strb
	);
		logic [31:0] res;
		res = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				res[k*8 +: 8] = data[k*8 +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------
	// bus and register state
	// ------------------------------------------------------------
	logic aw_have_reg, aw_have_next;
	logic [15:0] aw_addr_reg, aw_addr_next;
	logic w_have_reg, w_have_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [15:0] path_cfg_reg, path_cfg_next;
	logic [7:0] meas_mode_reg, meas_mode_next;
	logic [7:0] neutral_cfg_reg, neutral_cfg_next;
	logic soft_reset_reg, soft_reset_next;
	logic [31:0] merged;
	logic do_write;

	always_comb begin
		aw_have_next = aw_have_reg;
		aw_addr_next = aw_addr_reg;
		w_have_next = w_have_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		path_cfg_next = path_cfg_reg;
		meas_mode_next = meas_mode_reg;
		neutral_cfg_next = neutral_cfg_reg;
		soft_reset_next = 1'b0;
		merged = 32'h0000_0000;
		if (I_AXI_AWVALID && awready_reg) begin
			aw_have_next = 1'b1;
			aw_addr_next = I_AXI_AWADDR;
		end
		if (I_AXI_WVALID && wready_reg) begin
			w_have_next = 1'b1;
			w_data_next = I_AXI_WDATA;
			w_strb_next = I_AXI_WSTRB;
		end
		if (bvalid_reg && I_AXI_BREADY) begin
			bvalid_next = 1'b0;
		end
		do_write = aw_have_next && w_have_next && !bvalid_next;
		if (do_write) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = mpcr_pkg::RESP_OKAY;
			unique case (aw_addr_next & 16'hfffc)
				mpcr_pkg::PATH_CFG_ADDR: begin
					merged = lane_merge({16'h0000, path_cfg_reg}, w_data_next, w_strb_next);
					path_cfg_next = merged[15:0] & mpcr_pkg::PATH_CFG_LIVE_MASK;
				end
				mpcr_pkg::MEAS_MODE_ADDR: begin
					merged = lane_merge({24'h00_0000, meas_mode_reg}, w_data_next, w_strb_next);
					meas_mode_next = merged[7:0] & mpcr_pkg::MEAS_MODE_LIVE_MASK;
				end
				mpcr_pkg::NEUTRAL_CFG_ADDR: begin
					merged = lane_merge({24'h00_0000, neutral_cfg_reg}, w_data_next, w_strb_next);
					neutral_cfg_next = merged[7:0] & mpcr_pkg::NEUTRAL_CFG_LIVE_MASK;
				end
				default: begin
					bresp_next = mpcr_pkg::RESP_SLVERR;
				end
			endcase
			if (path_cfg_next[mpcr_pkg::SOFT_RESET_REQUEST_BIT]) begin
				soft_reset_next = 1'b1;
				path_cfg_next = mpcr_pkg::PATH_CFG_RESET;
				meas_mode_next = mpcr_pkg::MEAS_MODE_RESET;
				neutral_cfg_next = mpcr_pkg::NEUTRAL_CFG_RESET;
			end
		end
		if (rvalid_reg && I_AXI_RREADY) begin
			rvalid_next = 1'b0;
		end
		if (I_AXI_ARVALID && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = mpcr_pkg::RESP_OKAY;
			unique case (I_AXI_ARADDR & 16'hfffc)
				mpcr_pkg::PATH_CFG_ADDR: rdata_next = {16'h0000, path_cfg_reg};
				mpcr_pkg::MEAS_MODE_ADDR: rdata_next = {24'h00_0000, meas_mode_reg};
				mpcr_pkg::NEUTRAL_CFG_ADDR: rdata_next = {24'h00_0000, neutral_cfg_reg};
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = mpcr_pkg::RESP_SLVERR;
				end
			endcase
		end
		// one write and one read in flight; hold off until the response drains
		awready_next = !aw_have_next && !bvalid_next;
		wready_next = !w_have_next && !bvalid_next;
		arready_next = !rvalid_next;
	end

	always_ff @(posedge I_CLK) begin
		if (!I_RSTN) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 16'h0000;
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= mpcr_pkg::RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= mpcr_pkg::RESP_OKAY;
			path_cfg_reg <= mpcr_pkg::PATH_CFG_RESET;
			meas_mode_reg <= mpcr_pkg::MEAS_MODE_RESET;
			neutral_cfg_reg <= mpcr_pkg::NEUTRAL_CFG_RESET;
			soft_reset_reg <= 1'b0;
		end else if (I_CE) begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg <= w_have_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			path_cfg_reg <= path_cfg_next;
			meas_mode_reg <= meas_mode_next;
			neutral_cfg_reg <= neutral_cfg_next;
			soft_reset_reg <= soft_reset_next;
		end
	end

	// ------------------------------------------------------------
	// signal path steering
	// ------------------------------------------------------------
	logic pulse_sync1_reg, pulse_sync2_reg;
	logic fclk_sync1_reg, fclk_sync2_reg;
	mpcr_pkg::mpcr_samples_type chan_reg, chan_next;
	mpcr_pkg::mpcr_pair_type pair_reg, pair_next;
	logic period_zc_reg, period_zc_next;
	logic peak_zc_reg, peak_zc_next;
	logic [RMS_W-1:0] nrms_reg, nrms_next;
	logic pin_reg, pin_next;
	mpcr_pkg::mpcr_samples_type cur_src;
	logic [2:0] peak_sel;

	always_comb begin
		cur_src = path_cfg_reg[mpcr_pkg::INTEGRATOR_ENABLE_BIT] ? I_INTEG_SAMPLES : I_RAW_SAMPLES;
		chan_next = I_RAW_SAMPLES;
		chan_next.ia = cur_src.ia;
		chan_next.ib = cur_src.ib;
		chan_next.ic = cur_src.ic;
		chan_next.in = cur_src.in;
		if (path_cfg_reg[mpcr_pkg::VOLTAGE_ADC_GROUND_BIT]) begin
			chan_next.va = '0;
			chan_next.vb = '0;
			chan_next.vc = '0;
		end
		if (path_cfg_reg[mpcr_pkg::CURRENT_ADC_GROUND_BIT]) begin
			chan_next.ia = '0;
			chan_next.ib = '0;
			chan_next.ic = '0;
			chan_next.in = '0;
		end
		if (path_cfg_reg[mpcr_pkg::CHANNEL_SWAP_BIT]) begin
			// neutral has no voltage partner and stays in place
			{chan_next.va, chan_next.ia} = {chan_next.ia, chan_next.va};
			{chan_next.vb, chan_next.ib} = {chan_next.ib, chan_next.vb};
			{chan_next.vc, chan_next.ic} = {chan_next.ic, chan_next.vc};
		end
		// phase A, B and C pairing, code 11 as 00
		pair_next.va = pair_pick(path_cfg_reg[mpcr_pkg::PHASE_A_PAIRING_LSB +: 2],
			chan_next.va, chan_next.vb, chan_next.vc);
		pair_next.vb = pair_pick(path_cfg_reg[mpcr_pkg::PHASE_B_PAIRING_LSB +: 2],
			chan_next.vb, chan_next.vc, chan_next.va);
		pair_next.vc = pair_pick(path_cfg_reg[mpcr_pkg::PHASE_C_PAIRING_LSB +: 2],
			chan_next.vc, chan_next.va, chan_next.vb);
		// line period phase, 11 as 00
		unique case (meas_mode_reg[mpcr_pkg::LINE_PERIOD_SELECT_LSB +: 2])
			2'h1: period_zc_next = I_PHASE_ZERO_CROSS[1];
			2'h2: period_zc_next = I_PHASE_ZERO_CROSS[2];
			default: period_zc_next = I_PHASE_ZERO_CROSS[0];
		endcase
		peak_sel = meas_mode_reg[mpcr_pkg::PEAK_PHASE_SELECT_LSB +: 3];
		peak_zc_next = |(peak_sel & I_PHASE_ZERO_CROSS);
		nrms_next = neutral_cfg_reg[mpcr_pkg::NEUTRAL_RMS_SOURCE_BIT] ?
			I_NEUTRAL_RMS_ESTIMATED : I_NEUTRAL_RMS_MEASURED;
		// capture clock on shared pin, else pulse
		pin_next = path_cfg_reg[mpcr_pkg::FAST_CAPTURE_PORT_ENABLE_BIT] ? fclk_sync2_reg : pulse_sync2_reg;
	end

	// the pin sources come from outside the clock domain and are synchronised first;
	// the capture clock is thus resampled and only tracks slow clocks faithfully
	always_ff @(posedge I_CLK) begin
		if (!I_RSTN) begin
			pulse_sync1_reg <= 1'b0;
			pulse_sync2_reg <= 1'b0;
			fclk_sync1_reg <= 1'b0;
			fclk_sync2_reg <= 1'b0;
			chan_reg <= '0;
			pair_reg <= '0;
			period_zc_reg <= 1'b0;
			peak_zc_reg <= 1'b0;
			nrms_reg <= '0;
			pin_reg <= 1'b0;
		end else if (I_CE) begin
			pulse_sync1_reg <= I_THIRD_PULSE;
			pulse_sync2_reg <= pulse_sync1_reg;
			fclk_sync1_reg <= I_FAST_CAPTURE_CLOCK;
			fclk_sync2_reg <= fclk_sync1_reg;
			chan_reg <= chan_next;
			pair_reg <= pair_next;
			period_zc_reg <= period_zc_next;
			peak_zc_reg <= peak_zc_next;
			nrms_reg <= nrms_next;
			pin_reg <= pin_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign O_AXI_AWREADY = awready_reg;
	assign O_AXI_WREADY = wready_reg;
	assign O_AXI_BRESP = bresp_reg;
	assign O_AXI_BVALID = bvalid_reg;
	assign O_AXI_ARREADY = arready_reg;
	assign O_AXI_RDATA = rdata_reg;
	assign O_AXI_RRESP = rresp_reg;
	assign O_AXI_RVALID = rvalid_reg;
	assign O_CHANNEL_SAMPLES = chan_reg;
	assign O_POWER_VOLTAGE = pair_reg;
	assign O_LINE_PERIOD_ZERO_CROSS = period_zc_reg;
	assign O_PEAK_ZERO_CROSS = peak_zc_reg;
	assign O_PEAK_PHASE_SELECT = meas_mode_reg[mpcr_pkg::PEAK_PHASE_SELECT_LSB +: 3];
	assign O_NEUTRAL_RMS_RESULT = nrms_reg;
	assign O_FAST_CAPTURE_PORT_ENABLE = path_cfg_reg[mpcr_pkg::FAST_CAPTURE_PORT_ENABLE_BIT];
	assign O_THIRD_PULSE_PIN = pin_reg;
	assign O_SOFT_RESET = soft_reset_reg;

endmodule

`default_nettype wire

// ==== verification/mpcr_top_props.sv ====
// concurrent checks on the ports of the metering path configuration bank
`timescale 1ns/1ps
`default_nettype none

module mpcr_top_props (
	input wire logic I_CLK,
	input wire logic I_RSTN,
	input wire logic I_CE,
	input wire logic [15:0] I_AXI_AWADDR,
	input wire logic I_AXI_AWVALID,
	input wire logic O_AXI_AWREADY,
	input wire logic [31:0] I_AXI_WDATA,
	input wire logic [3:0] I_AXI_WSTRB,
	input wire logic I_AXI_WVALID,
	input wire logic O_AXI_WREADY,
	input wire logic [1:0] O_AXI_BRESP,
	input wire logic O_AXI_BVALID,
	input wire logic I_AXI_BREADY,
	input wire logic I_AXI_ARVALID,
	input wire logic O_AXI_ARREADY,
	input wire logic [31:0] O_AXI_RDATA,
	input wire logic O_AXI_RVALID,
	input wire logic I_AXI_RREADY,
	input wire logic [2:0] I_PHASE_ZERO_CROSS,
	input wire logic I_THIRD_PULSE,
	input wire logic I_FAST_CAPTURE_CLOCK,
	input wire logic O_PEAK_ZERO_CROSS,
	input wire logic [2:0] O_PEAK_PHASE_SELECT,
	input wire logic O_FAST_CAPTURE_PORT_ENABLE,
	input wire logic O_THIRD_PULSE_PIN,
	input wire logic O_SOFT_RESET
);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);

	a_write_answer: assert property (I_CE && I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY
		|=> O_AXI_BVALID) else $error("write not answered");
	a_read_answer: assert property (I_CE && I_AXI_ARVALID && O_AXI_ARREADY |=> O_AXI_RVALID && !O_AXI_ARREADY)
		else $error("read not answered");
	a_bresp_hold: assert property (O_AXI_BVALID && !(I_CE && I_AXI_BREADY) |=> O_AXI_BVALID && $stable(O_AXI_BRESP))
		else $error("write answer dropped");
	a_rdata_hold: assert property (O_AXI_RVALID && !(I_CE && I_AXI_RREADY) |=> O_AXI_RVALID && $stable(O_AXI_RDATA))
		else $error("read answer dropped");
	a_soft_reset_start: assert property (
		I_CE && I_AXI_AWVALID && O_AXI_AWREADY && I_AXI_WVALID && O_AXI_WREADY && I_AXI_WSTRB[0] && I_AXI_WDATA[7]
		&& I_AXI_AWADDR[15:2] == mpcr_pkg::PATH_CFG_ADDR[15:2] |-> ##[1:2] O_SOFT_RESET)
		else $error("no reset pulse after request");
	a_soft_reset_single: assert property (O_SOFT_RESET |=> !O_SOFT_RESET)
		else $error("reset pulse too long");
	// the pin path is three flops deep, so both sources are seen three cycles late
	a_pin_source: assert property ($past(I_RSTN, 4) && $past(I_CE) && $past(I_CE, 2) && $past(I_CE, 3)
		&& $past(O_FAST_CAPTURE_PORT_ENABLE) == $past(O_FAST_CAPTURE_PORT_ENABLE, 3) |-> O_THIRD_PULSE_PIN
		== ($past(O_FAST_CAPTURE_PORT_ENABLE) ? $past(I_FAST_CAPTURE_CLOCK, 3) : $past(I_THIRD_PULSE, 3)))
		else $error("wrong source on shared pin");
	a_peak_any_phase: assert property ($past(I_CE) && $past(I_RSTN)
		&& O_PEAK_PHASE_SELECT == $past(O_PEAK_PHASE_SELECT, 2)
		|-> O_PEAK_ZERO_CROSS == |($past(I_PHASE_ZERO_CROSS) & O_PEAK_PHASE_SELECT))
		else $error("peak crossing mismatch");
endmodule
`default_nettype wire

// ==== verification/mpcr_top_tb.sv ====
// self-checking bench for the metering path configuration bank
`timescale 1ns/1ps
`default_nettype none

module mpcr_top_tb;
	logic I_CLK, I_RSTN, I_CE, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY;
	logic [15:0] I_AXI_AWADDR, I_AXI_ARADDR;
	logic [31:0] I_AXI_WDATA, O_AXI_RDATA;
	logic [3:0] I_AXI_WSTRB;
	logic O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID;
	logic [1:0] O_AXI_BRESP, O_AXI_RRESP;
	mpcr_pkg::mpcr_samples_type I_RAW_SAMPLES, I_INTEG_SAMPLES, O_CHANNEL_SAMPLES;
	mpcr_pkg::mpcr_pair_type O_POWER_VOLTAGE;
	logic [2:0] I_PHASE_ZERO_CROSS, O_PEAK_PHASE_SELECT;
	logic [23:0] I_NEUTRAL_RMS_MEASURED, I_NEUTRAL_RMS_ESTIMATED, O_NEUTRAL_RMS_RESULT;
	logic I_THIRD_PULSE, I_FAST_CAPTURE_CLOCK, O_LINE_PERIOD_ZERO_CROSS, O_PEAK_ZERO_CROSS;
	logic O_FAST_CAPTURE_PORT_ENABLE, O_THIRD_PULSE_PIN, O_SOFT_RESET;
	int fails, checks_done, soft_seen;

	mpcr_top #(.RMS_W(24)) dut (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE),
		.I_AXI_AWADDR(I_AXI_AWADDR), .I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY),
		.I_AXI_WDATA(I_AXI_WDATA), .I_AXI_WSTRB(I_AXI_WSTRB), .I_AXI_WVALID(I_AXI_WVALID),
		.O_AXI_WREADY(O_AXI_WREADY), .O_AXI_BRESP(O_AXI_BRESP), .O_AXI_BVALID(O_AXI_BVALID),
		.I_AXI_BREADY(I_AXI_BREADY), .I_AXI_ARADDR(I_AXI_ARADDR), .I_AXI_ARVALID(I_AXI_ARVALID),
		.O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA), .O_AXI_RRESP(O_AXI_RRESP),
		.O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY), .I_RAW_SAMPLES(I_RAW_SAMPLES),
		.I_INTEG_SAMPLES(I_INTEG_SAMPLES), .I_PHASE_ZERO_CROSS(I_PHASE_ZERO_CROSS),
		.I_NEUTRAL_RMS_MEASURED(I_NEUTRAL_RMS_MEASURED), .I_NEUTRAL_RMS_ESTIMATED(I_NEUTRAL_RMS_ESTIMATED),
		.I_THIRD_PULSE(I_THIRD_PULSE), .I_FAST_CAPTURE_CLOCK(I_FAST_CAPTURE_CLOCK),
		.O_CHANNEL_SAMPLES(O_CHANNEL_SAMPLES), .O_POWER_VOLTAGE(O_POWER_VOLTAGE),
		.O_LINE_PERIOD_ZERO_CROSS(O_LINE_PERIOD_ZERO_CROSS), .O_PEAK_ZERO_CROSS(O_PEAK_ZERO_CROSS),
		.O_PEAK_PHASE_SELECT(O_PEAK_PHASE_SELECT), .O_NEUTRAL_RMS_RESULT(O_NEUTRAL_RMS_RESULT),
		.O_FAST_CAPTURE_PORT_ENABLE(O_FAST_CAPTURE_PORT_ENABLE), .O_THIRD_PULSE_PIN(O_THIRD_PULSE_PIN),
		.O_SOFT_RESET(O_SOFT_RESET));

	// ------------------------------------------------------------
	// bus tasks and compare
	// ------------------------------------------------------------
	task automatic chk(input logic [167:0] got, input logic [167:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s", $time, what);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge I_CLK);
		I_AXI_AWADDR <= a;
		I_AXI_WDATA <= d;
		I_AXI_AWVALID <= 1'b1;
		I_AXI_WVALID <= 1'b1;
		I_AXI_BREADY <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (O_AXI_AWREADY === 1'b1) I_AXI_AWVALID <= 1'b0;
			if (O_AXI_WREADY === 1'b1) I_AXI_WVALID <= 1'b0;
		end while (O_AXI_BVALID !== 1'b1);
		r = O_AXI_BRESP;
		I_AXI_BREADY <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge I_CLK);
		I_AXI_ARADDR <= a;
		I_AXI_ARVALID <= 1'b1;
		I_AXI_RREADY <= 1'b1;
		do begin
			@(posedge I_CLK);
			if (O_AXI_ARREADY === 1'b1) I_AXI_ARVALID <= 1'b0;
		end while (O_AXI_RVALID !== 1'b1);
		d = O_AXI_RDATA;
		r = O_AXI_RRESP;
		I_AXI_RREADY <= 1'b0;
	endtask

	task automatic rdc(input logic [15:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0] r;
		rd(a, q, r);
		chk({r, q}, {mpcr_pkg::RESP_OKAY, e}, "read value");
	endtask

	task automatic wrc(input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
		logic [1:0] r;
		wr(a, d, r);
		chk(r, mpcr_pkg::RESP_OKAY, "write answer");
		rdc(a, e);
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_defaults;
		logic [31:0] q;
		logic [1:0] r;
		rdc(mpcr_pkg::MEAS_MODE_ADDR, 32'h0000_001c);
		rdc(mpcr_pkg::NEUTRAL_CFG_ADDR, 32'h0000_0000);
		rdc(mpcr_pkg::PATH_CFG_ADDR, 32'h0000_0000);
		chk(O_PEAK_PHASE_SELECT, 3'b111, "peak select default");
		// an unmapped word must not alias onto a live register
		rd(16'h0010, q, r);
		chk({r, q}, {2'h2, 32'h0000_0000}, "unmapped read");
		wr(16'h0010, 32'hffff_ffff, r);
		chk(r, 2'h2, "unmapped write");
	endtask

	task automatic t_path(input logic [15:0] c);
		mpcr_pkg::mpcr_samples_type e;
		e = I_RAW_SAMPLES;
		if (c[0]) {e.ia, e.ib, e.ic, e.in} = I_INTEG_SAMPLES[95:0];
		if (c[4]) {e.va, e.vb, e.vc} = 72'h0;
		if (c[5]) {e.ia, e.ib, e.ic, e.in} = 96'h0;
		if (c[3]) {e.va, e.vb, e.vc, e.ia, e.ib, e.ic} = {e.ia, e.ib, e.ic, e.va, e.vb, e.vc};
		wrc(mpcr_pkg::PATH_CFG_ADDR, {16'h0000, c}, {16'h0000, c & 16'h3ff9});
		repeat (3) @(posedge I_CLK);
		#1;
		chk(O_CHANNEL_SAMPLES[167:24], e[167:24], "channel data");
		chk(O_CHANNEL_SAMPLES.in, e.in, "neutral data");
	endtask

	task automatic t_pair;
		logic [23:0] v [3];
		int k;
		v = '{I_RAW_SAMPLES.va, I_RAW_SAMPLES.vb, I_RAW_SAMPLES.vc};
		for (int c = 0; c < 4; c++) begin
			k = (c == 3) ? 0 : c;
			wrc(mpcr_pkg::PATH_CFG_ADDR, c * 32'h0000_1500, c * 32'h0000_1500);
			repeat (3) @(posedge I_CLK);
			#1;
			chk(O_POWER_VOLTAGE, {v[k], v[(k + 1) % 3], v[(k + 2) % 3]}, "pairing");
		end
	endtask

	task automatic t_port;
		logic [1:0] r;
		wr(mpcr_pkg::PATH_CFG_ADDR, 32'h0000_0040, r);
		@(posedge I_CLK);
		I_FAST_CAPTURE_CLOCK <= 1'b1;
		repeat (5) @(posedge I_CLK);
		#1;
		chk({O_FAST_CAPTURE_PORT_ENABLE, O_THIRD_PULSE_PIN}, 2'b11, "capture clock on pin");
		wr(mpcr_pkg::PATH_CFG_ADDR, 32'h0000_0000, r);
		@(posedge I_CLK);
		I_THIRD_PULSE <= 1'b1;
		// capture clock low so a pin stuck on it would show
		I_FAST_CAPTURE_CLOCK <= 1'b0;
		repeat (5) @(posedge I_CLK);
		#1;
		chk({O_FAST_CAPTURE_PORT_ENABLE, O_THIRD_PULSE_PIN}, 2'b01, "pulse on pin");
		@(posedge I_CLK);
		I_THIRD_PULSE <= 1'b0;
	endtask

	task automatic t_select;
		logic [2:0] pk;
		logic [7:0] md;
		int s;
		for (int m = 0; m < 4; m++) begin
			pk = (m == 3) ? 3'b111 : 3'b001 << m;
			s = (m == 3) ? 0 : m;
			md = {(m == 2) ? 3'b111 : 3'b000, pk, 2'(m)};
			wrc(mpcr_pkg::MEAS_MODE_ADDR, {24'h0, md}, {27'h0, md[4:0]});
			chk(O_PEAK_PHASE_SELECT, pk, "peak select");
			for (int p = 0; p < 3; p++) begin
				@(posedge I_CLK);
				I_PHASE_ZERO_CROSS <= 3'b001 << p;
				@(posedge I_CLK);
				I_PHASE_ZERO_CROSS <= 3'b000;
				#1;
				chk({O_LINE_PERIOD_ZERO_CROSS, O_PEAK_ZERO_CROSS}, {p == s, pk[p]}, "crossing");
			end
		end
	endtask

	task automatic t_neutral;
		wrc(mpcr_pkg::NEUTRAL_CFG_ADDR, 32'h0000_00fe, 32'h0000_0000);
		repeat (3) @(posedge I_CLK);
		#1;
		chk(O_NEUTRAL_RMS_RESULT, I_NEUTRAL_RMS_MEASURED, "measured rms");
		wrc(mpcr_pkg::NEUTRAL_CFG_ADDR, 32'h0000_0001, 32'h0000_0001);
		repeat (3) @(posedge I_CLK);
		#1;
		chk(O_NEUTRAL_RMS_RESULT, I_NEUTRAL_RMS_ESTIMATED, "estimated rms");
	endtask

	task automatic t_soft;
		logic [1:0] r;
		wrc(mpcr_pkg::MEAS_MODE_ADDR, 32'h0000_0003, 32'h0000_0003);
		soft_seen = 0;
		wr(mpcr_pkg::PATH_CFG_ADDR, 32'h0000_15b9, r);
		repeat (3) @(posedge I_CLK);
		#1;
		chk(soft_seen, 1, "one reset pulse");
		rdc(mpcr_pkg::PATH_CFG_ADDR, 32'h0000_0000);
		rdc(mpcr_pkg::MEAS_MODE_ADDR, 32'h0000_001c);
		rdc(mpcr_pkg::NEUTRAL_CFG_ADDR, 32'h0000_0000);
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge I_CLK) begin
		if (O_SOFT_RESET === 1'b1) soft_seen <= soft_seen + 1;
	end

	initial begin
		I_CLK = 1'b0;
		forever #4 I_CLK = ~I_CLK;
	end

	// the whole sequence needs a few hundred cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge I_CLK);
		fails++;
		summarize();
	end

	initial begin
		{I_RSTN, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY} = 6'h00;
		{I_AXI_AWADDR, I_AXI_ARADDR, I_AXI_WDATA} = 64'h0;
		{I_PHASE_ZERO_CROSS, I_THIRD_PULSE, I_FAST_CAPTURE_CLOCK} = 5'h00;
		I_CE = 1'b1;
		I_AXI_WSTRB = 4'hf;
		I_RAW_SAMPLES = {24'h11_1111, 24'h22_2222, 24'h33_3333, 24'h44_4444, 24'h55_5555, 24'h66_6666, 24'h77_7777};
		I_INTEG_SAMPLES = {72'h0, 24'h88_8888, 24'h99_9999, 24'haa_aaaa, 24'hbb_bbbb};
		I_NEUTRAL_RMS_MEASURED = 24'h12_3456;
		I_NEUTRAL_RMS_ESTIMATED = 24'h65_4321;
		fails = 0;
		checks_done = 0;
		repeat (12) @(posedge I_CLK);
		I_RSTN <= 1'b1;
		t_defaults();
		t_path(16'h0001);
		t_path(16'h0008);
		t_path(16'h0010);
		t_path(16'h0020);
		t_path(16'h0039);
		t_path(16'hc006);
		t_pair();
		t_port();
		t_select();
		t_neutral();
		t_soft();
		summarize();
	end
endmodule

bind mpcr_top mpcr_top_props u_props (.I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_CE(I_CE), .I_AXI_AWADDR(I_AXI_AWADDR),
	.I_AXI_AWVALID(I_AXI_AWVALID), .O_AXI_AWREADY(O_AXI_AWREADY), .I_AXI_WDATA(I_AXI_WDATA),
	.I_AXI_WSTRB(I_AXI_WSTRB), .I_AXI_WVALID(I_AXI_WVALID), .O_AXI_WREADY(O_AXI_WREADY),
	.O_AXI_BRESP(O_AXI_BRESP), .O_AXI_BVALID(O_AXI_BVALID), .I_AXI_BREADY(I_AXI_BREADY),
	.I_AXI_ARVALID(I_AXI_ARVALID), .O_AXI_ARREADY(O_AXI_ARREADY), .O_AXI_RDATA(O_AXI_RDATA),
	.O_AXI_RVALID(O_AXI_RVALID), .I_AXI_RREADY(I_AXI_RREADY), .I_PHASE_ZERO_CROSS(I_PHASE_ZERO_CROSS),
	.I_THIRD_PULSE(I_THIRD_PULSE), .I_FAST_CAPTURE_CLOCK(I_FAST_CAPTURE_CLOCK),
	.O_PEAK_ZERO_CROSS(O_PEAK_ZERO_CROSS), .O_PEAK_PHASE_SELECT(O_PEAK_PHASE_SELECT),
	.O_FAST_CAPTURE_PORT_ENABLE(O_FAST_CAPTURE_PORT_ENABLE), .O_THIRD_PULSE_PIN(O_THIRD_PULSE_PIN),
	.O_SOFT_RESET(O_SOFT_RESET));
`default_nettype wire
